// ---- dsi_ctrl.sv ----
// host controller driving the strobes, address and data of the memory
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - 24-bit address sent as two halves
// - address stable before each strobe fall
// - direction high reads, low writes
// - all 4096 rows refreshed every 64 ms
// - column-first refresh uses internal counter
// - 200 us pause then eight init cycles
module dsi_ctrl
   import dsi_pkg::*;
#(
   parameter int unsigned PWRUP_CYCLES = PWRUP_CYC,
   parameter int unsigned REF_CYCLES   = REF_INT_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              req_valid_i,
   input  wire logic [1:0]        req_op_i,
   input  wire logic [ADDR_W-1:0] req_addr_i,
   input  wire logic              req_data_i,
   input  wire logic              test_enter_i,
   input  wire logic              test_leave_i,
   output logic                   req_ready_o,
   output logic                   rsp_valid_o,
   output logic                   rsp_data_o,
   output logic                   init_done_o,
   output logic                   test_mode_o,
   output logic                   row_strobe_n_o,
   output logic                   column_strobe_n_o,
   output logic                   direction_select_o,
   output logic [HALF_W-1:0]      address_lines_o,
   output logic                   input_bit_o,
   input  wire logic              output_bit_i
);
   dsi_state_e        state_q;
   logic [31:0]       wait_q;
   logic [31:0]       ref_cnt_q;
   logic              ref_due_q;
   logic [3:0]        init_cnt_q;
   logic [1:0]        op_q;
   logic [ADDR_W-1:0] addr_q;
   logic              data_q;
   logic [1:0]        cbr_kind_q;
   logic              out_sync;
   logic              wait_done;
   logic              start_req;

   dsi_sync u_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (output_bit_i),
      .level_o   (out_sync)
   );

   assign wait_done   = (wait_q == 32'h0000_0000);
   assign req_ready_o = (state_q == DSI_IDLE) && init_done_o && !ref_due_q
                        && !test_enter_i && !test_leave_i;
   assign start_req   = req_ready_o && req_valid_i;

   // refresh interval timer, set wins over clear
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ref_cnt_q <= 32'h0000_0000;
         ref_due_q <= 1'b0;
      end else begin
         if (ref_cnt_q >= REF_CYCLES - 1) begin
            ref_cnt_q <= 32'h0000_0000;
            ref_due_q <= 1'b1;
         end else begin
            ref_cnt_q <= ref_cnt_q + 32'h0000_0001;
            if (state_q == DSI_CBR2 && cbr_kind_q == 2'h0) begin
               ref_due_q <= 1'b0;
            end
         end
      end
   end

   // main sequencer
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q            <= DSI_POWER;
         wait_q             <= 32'h0000_0000;
         init_cnt_q         <= 4'h0;
         init_done_o        <= 1'b0;
         test_mode_o        <= 1'b0;
         op_q               <= 2'h0;
         addr_q             <= '0;
         data_q             <= 1'b0;
         cbr_kind_q         <= 2'h0;
         rsp_valid_o        <= 1'b0;
         rsp_data_o         <= 1'b0;
         row_strobe_n_o     <= 1'b1;
         column_strobe_n_o  <= 1'b1;
         direction_select_o <= 1'b1;
         address_lines_o    <= '0;
         input_bit_o        <= 1'b0;
      end else begin
         rsp_valid_o <= 1'b0;
         if (!wait_done) begin
            wait_q <= wait_q - 32'h0000_0001;
         end
         unique case (state_q)
            DSI_POWER: begin
               if (wait_q == 32'h0000_0000 && init_cnt_q == 4'h0) begin
                  wait_q     <= PWRUP_CYCLES;
                  init_cnt_q <= CNT_W_ONE;
               end else if (wait_done) begin
                  cbr_kind_q <= 2'h0;
                  column_strobe_n_o <= 1'b0;
                  wait_q     <= STROBE_CYC;
                  state_q    <= DSI_CBR;
               end
            end
            DSI_IDLE: begin
               if (test_enter_i || test_leave_i || ref_due_q) begin
                  // direction low on a column-first refresh enters test
                  cbr_kind_q <= test_enter_i ? 2'h1 :
                                (test_leave_i ? 2'h2 : 2'h0);
                  // a refresh in test mode repeats the entry form
                  direction_select_o <= !test_enter_i
                                        && (test_leave_i || !test_mode_o);
                  column_strobe_n_o  <= 1'b0;
                  wait_q  <= STROBE_CYC;
                  state_q <= DSI_CBR;
               end else if (start_req) begin
                  op_q    <= req_op_i;
                  addr_q  <= req_addr_i;
                  data_q  <= req_data_i;
                  address_lines_o <= req_addr_i[ADDR_W-1:HALF_W];
                  wait_q  <= STROBE_CYC;
                  state_q <= DSI_ROW;
               end
            end
            DSI_ROW: begin
               if (wait_done && row_strobe_n_o) begin
                  row_strobe_n_o <= 1'b0;
                  wait_q <= STROBE_CYC;
               end else if (wait_done) begin
                  // column half placed before column strobe falls
                  address_lines_o <= addr_q[HALF_W-1:0];
                  direction_select_o <= (op_q != DSI_OP_WRITE);
                  input_bit_o <= data_q;
                  wait_q  <= ROW_ACCESS_CYC;
                  state_q <= DSI_COL;
               end
            end
            DSI_COL: begin
               if (wait_done && column_strobe_n_o) begin
                  column_strobe_n_o <= 1'b0;
                  wait_q <= ROW_ACCESS_CYC + SYNC_CYC;
               end else if (wait_done) begin
                  // sample after full access and synchroniser delay
                  rsp_data_o <= out_sync;
                  if (op_q == DSI_OP_RMW) begin
                     direction_select_o <= 1'b0;
                     wait_q  <= STROBE_CYC;
                     state_q <= DSI_WRITE;
                  end else begin
                     state_q <= DSI_CLOSE;
                  end
               end
            end
            DSI_WRITE: begin
               if (wait_done) begin
                  state_q <= DSI_CLOSE;
               end
            end
            DSI_CLOSE: begin
               rsp_valid_o        <= 1'b1;
               row_strobe_n_o     <= 1'b1;
               column_strobe_n_o  <= 1'b1;
               direction_select_o <= 1'b1;
               wait_q  <= PRECHARGE_CYC;
               state_q <= DSI_PRE;
            end
            DSI_PRE: begin
               if (wait_done) begin
                  direction_select_o <= 1'b1;
                  if (!init_done_o) begin
                     if (init_cnt_q == INIT_CYCLES[3:0]) begin
                        init_done_o <= 1'b1;
                        state_q     <= DSI_IDLE;
                     end else begin
                        init_cnt_q <= init_cnt_q + CNT_W_ONE;
                        column_strobe_n_o <= 1'b0;
                        wait_q  <= STROBE_CYC;
                        state_q <= DSI_CBR;
                     end
                  end else begin
                     state_q <= DSI_IDLE;
                  end
               end
            end
            DSI_CBR: begin
               if (wait_done) begin
                  row_strobe_n_o <= 1'b0;
                  wait_q  <= ROW_ACCESS_CYC;
                  state_q <= DSI_CBR2;
               end
            end
            DSI_CBR2: begin
               if (wait_done) begin
                  if (cbr_kind_q == 2'h1) begin
                     test_mode_o <= 1'b1;
                  end else if (cbr_kind_q == 2'h2) begin
                     test_mode_o <= 1'b0;
                  end
                  row_strobe_n_o    <= 1'b1;
                  column_strobe_n_o <= 1'b1;
                  wait_q  <= PRECHARGE_CYC;
                  state_q <= DSI_PRE;
               end
            end
         endcase
      end
   end

   // refresh cycles have column strobe low before row strobe falls
   cbr_order_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      ($fell(row_strobe_n_o) && state_q == DSI_CBR2) |->
      (!column_strobe_n_o && !$past(column_strobe_n_o)))
      else $error("column strobe not low before refresh row strobe");
   // no access cycle runs before initialisation completes
   init_gate_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !init_done_o |->
      (state_q inside {DSI_POWER, DSI_CBR, DSI_CBR2, DSI_PRE}))
      else $error("access cycle before initialisation");
   // early write keeps direction low at column strobe fall
   early_write_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      ($fell(column_strobe_n_o) && op_q == DSI_OP_WRITE
       && state_q == DSI_COL) |-> !direction_select_o)
      else $error("early write direction not low");
   // a read keeps direction high while column strobe is low
   read_dir_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (state_q == DSI_COL && op_q == DSI_OP_READ) |-> direction_select_o)
      else $error("read cycle drove direction low");
   // the row half is on the lines when row strobe falls
   row_addr_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      ($fell(row_strobe_n_o) && state_q == DSI_ROW) |->
      address_lines_o == addr_q[ADDR_W-1:HALF_W])
      else $error("row address wrong at row strobe");
   // column strobe never falls without row strobe low in an access
   col_order_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      ($fell(column_strobe_n_o) && state_q == DSI_COL) |->
      !row_strobe_n_o ##1 $stable(address_lines_o))
      else $error("column strobe fell out of order");
   // refresh request is serviced within a bounded time
   ref_serve_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      ($rose(ref_due_q) && state_q == DSI_IDLE && init_done_o) |->
      ##[1:40] (state_q == DSI_CBR2))
      else $error("refresh not started in time");
   // a test entry cycle sets test mode at its end
   test_entry_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (state_q == DSI_CBR2 && wait_done && cbr_kind_q == 2'h1) |=>
      test_mode_o)
      else $error("test mode not entered");
endmodule : dsi_ctrl
`default_nettype wire

// ---- dsi_dram_model.sv ----
// behavioural memory device answering the controller strobes
`timescale 1ns/10ps
`default_nettype none
module dsi_dram_model #(
   parameter int ACC_NS = 25
) (
   input  wire logic        row_strobe_n_i,
   input  wire logic        column_strobe_n_i,
   input  wire logic        direction_select_i,
   input  wire logic [11:0] address_lines_i,
   input  wire logic        input_bit_i,
   output logic             output_bit_o,
   output var int           refresh_cnt_o,
   output logic             test_o
);
   bit          mem [int];
   logic [15:0] tmem [int];
   logic [11:0] row_q = 12'h000;
   logic [11:0] ref_row_q = 12'h000;
   logic        cbr_q = 1'b0;
   logic        drv_q = 1'b0;
   logic        val_q = 1'b0;
   int          key;
   initial refresh_cnt_o = 0;
   initial test_o = 1'b0;
   // a released output shows the inverse of the last value
   assign output_bit_o = drv_q ? val_q : ~val_q;
   function automatic int tkey(input int k);
      return k & 32'h00ff_f3fc;
   endfunction
   task automatic store(input logic d);
      if (test_o) tmem[tkey(key)] = {16{d}};
      else mem[key] = d;
   endtask
   always @(negedge row_strobe_n_i) begin
      if (!column_strobe_n_i) begin
         cbr_q = 1'b1;
         ref_row_q = ref_row_q + 12'h001;
         refresh_cnt_o = refresh_cnt_o + 1;
         test_o = !direction_select_i;
      end else begin
         cbr_q = 1'b0;
         row_q = address_lines_i;
      end
   end
   always @(negedge column_strobe_n_i) begin
      if (!row_strobe_n_i && !cbr_q) begin
         key = {8'h00, row_q, address_lines_i};
         if (!direction_select_i) begin
            store(input_bit_i);
         end else begin
            #ACC_NS;
            if (test_o) val_q = tmem.exists(tkey(key)) &&
               (tmem[tkey(key)] == 16'h0000 ||
                tmem[tkey(key)] == 16'hffff);
            else val_q = mem.exists(key) ? mem[key] : 1'b0;
            drv_q = 1'b1;
         end
      end
   end
   // delayed write, output keeps the value just read
   always @(negedge direction_select_i) begin
      if (!column_strobe_n_i && !row_strobe_n_i && !cbr_q) begin
         store(input_bit_i);
      end
   end
   always @(posedge column_strobe_n_i) drv_q = 1'b0;
endmodule // dsi_dram_model
`default_nettype wire

// ---- dsi_pkg.sv ----
// constants for the strobe-interface memory controller
package dsi_pkg;
   localparam int unsigned CLK_MHZ        = 25;
   localparam int unsigned ADDR_W         = 24;
   localparam int unsigned HALF_W         = 12;
   localparam int unsigned ROWS           = 4096;
   localparam int unsigned PWRUP_US       = 200;
   localparam int unsigned PWRUP_CYC      = PWRUP_US * CLK_MHZ;
   localparam int unsigned INIT_CYCLES    = 8;
   localparam int unsigned REFRESH_MS     = 64;
   // spread of refreshes over the period, rounded down
   localparam int unsigned REF_INT_CYC    =
      (REFRESH_MS * 1000 * CLK_MHZ) / ROWS;
   // access and strobe phase lengths, in clocks of 40 ns
   localparam int unsigned ROW_ACCESS_NS  = 100;
   localparam int unsigned ROW_ACCESS_CYC = (ROW_ACCESS_NS + 39) / 40;
   localparam int unsigned PRECHARGE_NS   = 80;
   localparam int unsigned PRECHARGE_CYC  = (PRECHARGE_NS + 39) / 40;
   localparam int unsigned STROBE_NS      = 40;
   localparam int unsigned STROBE_CYC     = (STROBE_NS + 39) / 40;
   // extra clocks for the output bit to pass the synchroniser
   localparam int unsigned SYNC_CYC       = 3;
   localparam logic [3:0]  CNT_W_ONE      = 4'h1;
   typedef enum logic [8:0] {
      DSI_POWER = 9'b0_0000_0001,
      DSI_IDLE  = 9'b0_0000_0010,
      DSI_ROW   = 9'b0_0000_0100,
      DSI_COL   = 9'b0_0000_1000,
      DSI_WRITE = 9'b0_0001_0000,
      DSI_CLOSE = 9'b0_0010_0000,
      DSI_PRE   = 9'b0_0100_0000,
      DSI_CBR   = 9'b0_1000_0000,
      DSI_CBR2  = 9'b1_0000_0000
   } dsi_state_e;
   typedef enum logic [1:0] {
      DSI_OP_READ  = 2'h0,
      DSI_OP_WRITE = 2'h1,
      DSI_OP_RMW   = 2'h2
   } dsi_op_e;
endpackage : dsi_pkg

// ---- dsi_sync.sv ----
// three-stage synchroniser for the memory output bit
`timescale 1ns/10ps
`default_nettype none
module dsi_sync (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic async_i,
   output logic      level_o
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s1_q    <= 1'b0;
         s2_q    <= 1'b0;
         s3_q    <= 1'b0;
         level_o <= 1'b0;
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_o <= s3_q;
         end
      end
   end
endmodule : dsi_sync
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the strobe-interface controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import dsi_pkg::*;
   logic              clk_i = 1'b0;
   logic              sys_rst_i = 1'b1;
   logic              req_valid_i = 1'b0;
   logic [1:0]        req_op_i = 2'h0;
   logic [ADDR_W-1:0] req_addr_i = '0;
   logic              req_data_i = 1'b0;
   logic              test_enter_i = 1'b0;
   logic              test_leave_i = 1'b0;
   logic              req_ready_o, rsp_valid_o, rsp_data_o, init_done_o;
   logic              test_mode_o, rs_n, cs_n, dir, din, dout, tst;
   logic [HALF_W-1:0] addr;
   int                errors = 0, checked = 0, cyc = 0, seed, rcnt, i, rc;
   logic [1:0]        expq [$];
   logic [1:0]        e;
   logic [23:0]       adr [6];
   logic              dat [6];
   always #20 clk_i = ~clk_i;
   dsi_ctrl #(.PWRUP_CYCLES(20), .REF_CYCLES(50)) DUT (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
      .req_op_i(req_op_i), .req_addr_i(req_addr_i),
      .req_data_i(req_data_i), .test_enter_i(test_enter_i),
      .test_leave_i(test_leave_i), .req_ready_o(req_ready_o),
      .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
      .init_done_o(init_done_o), .test_mode_o(test_mode_o),
      .row_strobe_n_o(rs_n), .column_strobe_n_o(cs_n),
      .direction_select_o(dir), .address_lines_o(addr),
      .input_bit_o(din), .output_bit_i(dout));
   dsi_dram_model MEM (
      .row_strobe_n_i(rs_n), .column_strobe_n_i(cs_n),
      .direction_select_i(dir), .address_lines_i(addr),
      .input_bit_i(din), .output_bit_o(dout), .refresh_cnt_o(rc),
      .test_o(tst));
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         errors++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // hold the request until the edge that takes it, note the result
   task automatic acc(input logic [1:0] op, input logic [23:0] a,
                      input logic d, input logic care, input logic x);
      @(posedge clk_i);
      req_op_i    <= op;
      req_addr_i  <= a;
      req_data_i  <= d;
      req_valid_i <= 1'b1;
      do @(negedge clk_i); while (req_ready_o !== 1'b1);
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      expq.push_back({care, x});
   endtask
   task automatic drain(input string n);
      for (int k = 0; k < 400 && expq.size() > 0; k++) @(posedge clk_i);
      chk(expq.size() == 0, "missing responses");
      $display("test %s done", n);
   endtask
   task automatic readback();
      for (int k = 0; k < 6; k++) acc(2'h0, adr[k], 1'b0, 1'b1, dat[k]);
   endtask
   always @(posedge clk_i) begin
      if (rsp_valid_o === 1'b1) begin
         if (expq.size() == 0) chk(1'b0, "unexpected response");
         else begin
            e = expq.pop_front();
            if (e[1]) chk(rsp_data_o === e[0], "read data");
         end
      end
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         errors++;
         $display("Error at %0t: timeout", $time);
         close_out();
      end
   end
   initial begin
      seed = 32'h9620ad74;
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (i = 0; i < 2000 && init_done_o !== 1'b1; i++) @(posedge clk_i);
      chk(init_done_o === 1'b1 && rc >= 8, "power-up");
      $display("test init done");
      for (i = 0; i < 6; i++) begin
         adr[i] = 24'($random(seed));
         dat[i] = 1'($random(seed));
         acc(2'h1, adr[i], dat[i], 1'b0, 1'b0);
      end
      readback();
      drain("write read");
      acc(2'h2, adr[0], ~dat[0], 1'b1, dat[0]);
      dat[0] = ~dat[0];
      acc(2'h0, adr[0], 1'b0, 1'b1, dat[0]);
      drain("read modify write");
      rcnt = rc;
      repeat (300) @(posedge clk_i);
      chk(rc - rcnt >= 5, "refresh rate");
      readback();
      drain("refresh");
      @(posedge clk_i);
      test_enter_i <= 1'b1;
      for (i = 0; i < 200 && test_mode_o !== 1'b1; i++) @(posedge clk_i);
      test_enter_i <= 1'b0;
      chk(test_mode_o === 1'b1 && tst === 1'b1, "test entry");
      acc(2'h1, adr[1], 1'b1, 1'b0, 1'b0);
      repeat (60) @(posedge clk_i);
      chk(test_mode_o === tst && tst === 1'b1, "test kept");
      acc(2'h0, adr[1] ^ 24'h00_0c03, 1'b0, 1'b1, 1'b1);
      drain("test mode");
      @(posedge clk_i);
      test_leave_i <= 1'b1;
      for (i = 0; i < 200 && test_mode_o !== 1'b0; i++) @(posedge clk_i);
      test_leave_i <= 1'b0;
      chk(test_mode_o === 1'b0 && tst === 1'b0, "test exit");
      $display("test leave done");
      close_out();
   end
endmodule // tb_top
`default_nettype wire
